// ### inc/dcxm_map.svh
// constants of the external-master dram controller port: offsets, fields, resets, counts
// assumes a 25 MHz system clock and a 28-bit external address bus
`ifndef DCXM_MAP_SVH
`define DCXM_MAP_SVH
`define DCXM_AW 28
`define DCXM_ROW_LSB 9
`define DCXM_COL_W 19
`define DCXM_NBANK 2
`define DCXM_RATE_W 12
`define DCXM_RATE_RST 12'h000
`define DCXM_TMG_RST 16'h0000
`define DCXM_TMG_DRIVE_EN 15
`define DCXM_TMG_RP_LSB 0
`define DCXM_TMG_RCD_LSB 2
`define DCXM_TMG_CASW_LSB 4
`define DCXM_RP_MIN 3'h1
`define DCXM_REF_SLOW 16'hffff
`define DCXM_REF_LAST 3'h4
`define DCXM_SIZ_LONG 2'h0
`define DCXM_SIZ_BYTE 2'h1
`define DCXM_SIZ_WORD 2'h2
`define DCXM_OFF_ADDR 8'h00
`define DCXM_OFF_CTRL 8'h04
`define DCXM_OFF_START 8'h08
`define DCXM_OFF_WDATA 8'h0c
`define DCXM_OFF_RDATA 8'h10
`define DCXM_OFF_STATUS 8'h14
`define DCXM_CTRL_READ 0
`define DCXM_CTRL_SIZ_LSB 1
`define DCXM_CTRL_RELEASE 3
`define DCXM_ST_BUSY 0
`define DCXM_ST_DONE 1
`define DCXM_ST_NOACK 2
`define DCXM_ACK_WAIT 64
`endif

// ### inc/dcxm_pkg.sv
// types shared by both ends of the external-master dram port
// assumes dcxm_map.svh for all figures
package dcxm_pkg;
   typedef logic [27:0] dcxm_addr_type;
   typedef enum logic [2:0] {DX_IDLE, DX_DEC, DX_WAIT, DX_ROW, DX_COL, DX_ACK, DX_FLT} dcxm_dev_state_type;
   typedef enum logic [1:0] {MX_IDLE, MX_START, MX_WAIT} dcxm_mst_state_type;
endpackage

// ### inc/dcxm_if.sv
// link between the external bus master and the dram controller port
// assumes the bench drives dram_rdata as the dram read data on the data bus
`timescale 1ns/1ns
`default_nettype none
interface dcxm_if (
   input wire logic clk // system clock
);
   import dcxm_pkg::*;
   dcxm_addr_type m_addr, d_addr, addr;
   logic m_addr_oe, d_addr_oe, m_read, transfer_start_n, m_data_oe;
   logic transfer_ack_n, ack_oe, dram_write_n;
   logic [1:0] xfer_size_code;
   logic [1:0] ras_n;
   logic [3:0] cas_n;
   logic [31:0] m_data, dram_rdata;
   // shared address wire; an undriven bus reads as zero
   assign addr = m_addr_oe ? m_addr : (d_addr_oe ? d_addr : '0);
   modport dev(input clk, addr, m_read, xfer_size_code, transfer_start_n,
      output d_addr, d_addr_oe, transfer_ack_n, ack_oe, ras_n, cas_n, dram_write_n);
   modport mst(input clk, transfer_ack_n, ack_oe, dram_rdata,
      output m_addr, m_addr_oe, m_read, xfer_size_code, transfer_start_n, m_data, m_data_oe);
endinterface
`default_nettype wire

// ### verilog/dcxm_refresh.sv
// refresh timer and cas-before-ras sequencer of the dram controller port
// assumes the caller tells it when an external transfer or a precharge holds the dram
`timescale 1ns/1ns
`default_nettype none
`include "dcxm_map.svh"
module dcxm_refresh (
   input wire logic clk, // system clock
   input wire logic rst_n, // master reset only
   input wire logic rate_wr, // refresh rate register written
   input wire logic [11:0] rate, // rate field
   input wire logic ext_busy, // external transfer owns the dram
   input wire logic pre_busy, // precharge not yet met
   output logic ref_ras, // row strobe wanted
   output logic ref_cas, // column strobe wanted
   output logic ref_end, // last cycle of a refresh
   output logic ref_hold // refresh pending or running
);
   logic [15:0] cnt;
   logic [2:0] seq;
   logic pending;
   logic [15:0] period_m1;
   logic start;

   assign period_m1 = (rate == 12'h000) ? `DCXM_REF_SLOW : 16'({rate, 4'h0} - 16'h0001);
   assign start = pending && (seq == 3'h0) && !ext_busy && !pre_busy;
   assign ref_ras = (seq >= 3'h2);
   assign ref_cas = (seq != 3'h0);
   assign ref_end = (seq == `DCXM_REF_LAST);
   assign ref_hold = pending || (seq != 3'h0);

   // only master reset touches the timer, normal reset does not reach here
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt <= `DCXM_REF_SLOW;
      end else if (rate_wr || cnt == 16'h0000) begin
         cnt <= period_m1;
      end else begin
         cnt <= 16'(cnt - 16'h0001);
      end
   end

   // a new request beats the clear; a write during a running cycle adds none
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pending <= 1'b0;
      end else if (cnt == 16'h0000 || (rate_wr && seq == 3'h0)) begin
         pending <= 1'b1;
      end else if (start) begin
         pending <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         seq <= 3'h0;
      end else if (start) begin
         seq <= 3'h1;
      end else if (ref_end) begin
         seq <= 3'h0;
      end else if (seq != 3'h0) begin
         seq <= 3'(seq + 3'h1);
      end
   end
endmodule
`default_nettype wire

// ### verilog/dcxm_device.sv
// dram controller end serving transfers started by an external bus master
// assumes the master keeps to the link protocol and only nonburst transfers occur
//
// The AHB-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "dcxm_map.svh"
module dcxm_device #(
   parameter int NBANK = `DCXM_NBANK // number of dram banks
) (
   input wire logic clk, // system clock
   input wire logic rst_n, // master reset
   input wire logic norm_rst_n, // normal reset
   dcxm_if.dev bus, // link to master and dram
   input wire logic rate_wr, // write refresh_rate_reg
   input wire logic [11:0] rate_wdata, // new refresh rate
   input wire logic timing_wr, // write dram_timing_reg
   input wire logic [15:0] timing_wdata, // new timing value
   input wire logic [NBANK-1:0] bank_en, // bank enables
   input wire dcxm_pkg::dcxm_addr_type [NBANK-1:0] bank_base, // bank base addresses
   input wire dcxm_pkg::dcxm_addr_type [NBANK-1:0] bank_mask, // bank don't-care bits
   output logic [11:0] refresh_rate_reg, // refresh rate readback
   output logic [15:0] dram_timing_reg, // timing readback
   output logic busy // external transfer in hand
);
   import dcxm_pkg::*;

   if (NBANK < 1 || NBANK > `DCXM_NBANK) begin : g_bad
      $error("bank count not supported by the link");
   end

   dcxm_dev_state_type state;
   dcxm_addr_type cap_addr;
   logic cap_read;
   logic [1:0] cap_siz;
   logic [NBANK-1:0] hit;
   logic [NBANK-1:0] cap_bank;
   logic [1:0] wait_cnt;
   logic [2:0] pre_cnt;
   logic ext_ras;
   logic ext_cas;
   logic [3:0] lanes;
   logic fsm_rst;
   logic ext_busy;
   logic ready;
   logic go_row;
   logic row_done;
   logic col_done;
   logic ref_ras;
   logic ref_cas;
   logic ref_end;
   logic ref_hold;
   logic drive_en;
   logic [1:0] rp;
   logic [1:0] rcd;
   logic [1:0] casw;

   assign drive_en = dram_timing_reg[`DCXM_TMG_DRIVE_EN];
   assign rp = dram_timing_reg[`DCXM_TMG_RP_LSB +: 2];
   assign rcd = dram_timing_reg[`DCXM_TMG_RCD_LSB +: 2];
   assign casw = dram_timing_reg[`DCXM_TMG_CASW_LSB +: 2];
   assign fsm_rst = !rst_n || !norm_rst_n;
   assign ext_busy = (state == DX_ROW) || (state == DX_COL) || (state == DX_ACK);
   assign ready = !ref_hold && (pre_cnt == 3'h0);
   assign go_row = ready && ((state == DX_DEC && |hit) || state == DX_WAIT);
   assign row_done = (state == DX_ROW) && (wait_cnt == 2'h0);
   assign col_done = (state == DX_COL) && (wait_cnt == 2'h0);

   // bank window compare, one per bank
   for (genvar b = 0; b < NBANK; b++) begin : g_bank
      assign hit[b] = bank_en[b] && (((cap_addr ^ bank_base[b]) & ~bank_mask[b]) == '0);
   end

   // byte lanes of a 32-bit port; column strobe 0 serves the top lane
   always_comb begin
      unique case (cap_siz)
         `DCXM_SIZ_BYTE: lanes = 4'h1 << cap_addr[1:0];
         `DCXM_SIZ_WORD: lanes = cap_addr[1] ? 4'hc : 4'h3;
         default: lanes = 4'hf;
      endcase
   end

   // programmable registers answer to master reset only
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         refresh_rate_reg <= `DCXM_RATE_RST;
         dram_timing_reg <= `DCXM_TMG_RST;
      end else begin
         if (rate_wr) begin
            refresh_rate_reg <= rate_wdata;
         end
         if (timing_wr) begin
            dram_timing_reg <= timing_wdata;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (fsm_rst) begin
         state <= DX_IDLE;
         cap_addr <= '0;
         cap_read <= 1'b1;
         cap_siz <= `DCXM_SIZ_LONG;
         cap_bank <= '0;
         wait_cnt <= 2'h0;
      end else begin
         unique case (state)
            DX_IDLE, DX_FLT: begin
               if (!bus.transfer_start_n) begin
                  cap_addr <= bus.addr;
                  cap_read <= bus.m_read;
                  cap_siz <= bus.xfer_size_code;
                  state <= DX_DEC;
               end else begin
                  state <= DX_IDLE;
               end
            end
            DX_DEC: begin
               cap_bank <= hit;
               wait_cnt <= rcd;
               if (~|hit) begin
                  state <= DX_IDLE;
               end else if (ready) begin
                  state <= DX_ROW;
               end else begin
                  state <= DX_WAIT;
               end
            end
            DX_WAIT: begin
               if (ready) begin
                  state <= DX_ROW;
               end
            end
            DX_ROW: begin
               if (wait_cnt == 2'h0) begin
                  wait_cnt <= casw;
                  state <= DX_COL;
               end else begin
                  wait_cnt <= 2'(wait_cnt - 2'h1);
               end
            end
            DX_COL: begin
               if (wait_cnt == 2'h0) begin
                  state <= DX_ACK;
               end else begin
                  wait_cnt <= 2'(wait_cnt - 2'h1);
               end
            end
            DX_ACK: state <= DX_FLT;
         endcase
      end
   end

   // address, write line and strobe requests of the external transfer
   always_ff @(posedge clk) begin
      if (fsm_rst) begin
         bus.d_addr <= '0;
         bus.d_addr_oe <= 1'b0;
         bus.dram_write_n <= 1'b1;
         ext_ras <= 1'b0;
         ext_cas <= 1'b0;
      end else if (go_row) begin
         bus.d_addr <= cap_addr;
         bus.d_addr_oe <= drive_en;
         bus.dram_write_n <= cap_read;
         ext_ras <= 1'b1;
      end else if (row_done) begin
         bus.d_addr[27:`DCXM_ROW_LSB] <= cap_addr[`DCXM_COL_W-1:0];
         ext_cas <= 1'b1;
      end else if (state == DX_ACK) begin
         bus.d_addr_oe <= 1'b0;
         bus.dram_write_n <= 1'b1;
         ext_ras <= 1'b0;
         ext_cas <= 1'b0;
      end
   end

   // acknowledge is driven high first, low for one cycle, high for one more, then released
   always_ff @(posedge clk) begin
      if (fsm_rst) begin
         bus.transfer_ack_n <= 1'b1;
         bus.ack_oe <= 1'b0;
      end else if (row_done) begin
         bus.transfer_ack_n <= 1'b1;
         bus.ack_oe <= 1'b1;
      end else if (col_done) begin
         bus.transfer_ack_n <= 1'b0;
      end else if (state == DX_ACK) begin
         bus.transfer_ack_n <= 1'b1;
      end else if (state == DX_FLT) begin
         bus.ack_oe <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (fsm_rst) begin
         busy <= 1'b0;
      end else begin
         busy <= (state != DX_IDLE);
      end
   end

   // precharge window after the row strobe release at acknowledge or at refresh end, survives normal reset
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pre_cnt <= 3'h0;
      end else if (state == DX_ACK || ref_end) begin
         pre_cnt <= 3'(`DCXM_RP_MIN + {1'b0, rp});
      end else if (pre_cnt != 3'h0) begin
         pre_cnt <= 3'(pre_cnt - 3'h1);
      end
   end

   // strobes change on the falling edge, half a clock after the request
   always_ff @(negedge clk) begin
      if (!rst_n) begin
         bus.ras_n <= '1;
         bus.cas_n <= '1;
      end else begin
         for (int b = 0; b < `DCXM_NBANK; b++) begin
            bus.ras_n[b] <= !(ref_ras || (b < NBANK && ext_ras && cap_bank[b]));
         end
         bus.cas_n <= ~((ext_cas ? lanes : 4'h0) | {4{ref_cas}});
      end
   end

   dcxm_refresh u_refresh (
      .clk(clk),
      .rst_n(rst_n),
      .rate_wr(rate_wr),
      // a write reloads from the new value; later periods come from the stored register
      .rate(rate_wr ? rate_wdata : refresh_rate_reg),
      .ext_busy(ext_busy),
      .pre_busy(pre_cnt != 3'h0),
      .ref_ras(ref_ras),
      .ref_cas(ref_cas),
      .ref_end(ref_end),
      .ref_hold(ref_hold)
   );
endmodule
`default_nettype wire

// ### verilog/dcxm_master.sv
// external bus master end, commanded by software over ahb-lite
// assumes software places write data on the lanes that the dram port needs
`timescale 1ns/1ns
`default_nettype none
`include "dcxm_map.svh"
module dcxm_master #(
   parameter int ACK_WAIT = `DCXM_ACK_WAIT // cycles to wait for acknowledge
) (
   input wire logic clk, // system clock
   input wire logic rst_n, // reset
   dcxm_if.mst bus, // link to the device
   input wire logic hsel, // slave select
   input wire logic [31:0] haddr, // byte address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write access
   input wire logic [2:0] hsize, // word only
   input wire logic [31:0] hwdata, // write data
   input wire logic hready, // bus ready
   output logic hreadyout, // always ready
   output logic [31:0] hrdata, // read data
   output logic hresp // always okay
);
   import dcxm_pkg::*;

   if (ACK_WAIT < 8 || ACK_WAIT > 65535) begin : g_bad
      $error("acknowledge wait out of range");
   end

   dcxm_mst_state_type state;
   dcxm_addr_type xfer_addr;
   logic [3:0] ctrl;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic done;
   logic noack;
   logic [15:0] wait_cnt;
   logic ap_valid;
   logic ap_wr;
   logic [7:0] ap_off;
   logic wr_ok;
   logic go;
   logic acked;
   logic timeout;

   assign wr_ok = ap_valid && ap_wr;
   assign go = wr_ok && ap_off == `DCXM_OFF_START && state == MX_IDLE;
   assign acked = (state == MX_WAIT) && bus.ack_oe && !bus.transfer_ack_n;
   assign timeout = (state == MX_WAIT) && !acked && wait_cnt == 16'(ACK_WAIT - 1);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ap_valid <= 1'b0;
         ap_wr <= 1'b0;
         ap_off <= 8'h00;
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         ap_valid <= hsel && htrans[1] && hready;
         ap_wr <= hwrite;
         ap_off <= haddr[7:0];
         if (hsel && htrans[1] && hready && !hwrite) begin
            unique case (haddr[7:0])
               `DCXM_OFF_ADDR: hrdata <= {4'h0, xfer_addr};
               `DCXM_OFF_CTRL: hrdata <= {28'h0, ctrl};
               `DCXM_OFF_WDATA: hrdata <= wdata;
               `DCXM_OFF_RDATA: hrdata <= rdata;
               `DCXM_OFF_STATUS: hrdata <= {29'h0, noack, done, state != MX_IDLE};
               default: hrdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         xfer_addr <= '0;
         ctrl <= 4'h0;
         wdata <= 32'h0000_0000;
      end else if (wr_ok) begin
         if (ap_off == `DCXM_OFF_ADDR) begin
            xfer_addr <= hwdata[27:0];
         end
         if (ap_off == `DCXM_OFF_CTRL) begin
            ctrl <= hwdata[3:0];
         end
         if (ap_off == `DCXM_OFF_WDATA) begin
            wdata <= hwdata;
         end
      end
   end

   // sticky flags: a setting event wins over a software clear
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         done <= 1'b0;
         noack <= 1'b0;
      end else begin
         done <= acked || (done && !(wr_ok && ap_off == `DCXM_OFF_STATUS && hwdata[`DCXM_ST_DONE]));
         noack <= timeout || (noack && !(wr_ok && ap_off == `DCXM_OFF_STATUS && hwdata[`DCXM_ST_NOACK]));
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state <= MX_IDLE;
         wait_cnt <= 16'h0000;
         rdata <= 32'h0000_0000;
         bus.m_addr <= '0;
         bus.m_addr_oe <= 1'b0;
         bus.m_read <= 1'b1;
         bus.xfer_size_code <= `DCXM_SIZ_LONG;
         bus.transfer_start_n <= 1'b1;
         bus.m_data <= 32'h0000_0000;
         bus.m_data_oe <= 1'b0;
      end else begin
         unique case (state)
            MX_IDLE: begin
               if (go) begin
                  bus.m_addr <= xfer_addr;
                  bus.m_addr_oe <= 1'b1;
                  bus.m_read <= ctrl[`DCXM_CTRL_READ];
                  bus.xfer_size_code <= ctrl[`DCXM_CTRL_SIZ_LSB +: 2];
                  bus.transfer_start_n <= 1'b0;
                  bus.m_data <= wdata;
                  bus.m_data_oe <= !ctrl[`DCXM_CTRL_READ];
                  wait_cnt <= 16'h0000;
                  state <= MX_START;
               end
            end
            MX_START: begin
               bus.transfer_start_n <= 1'b1;
               if (ctrl[`DCXM_CTRL_RELEASE]) begin
                  bus.m_addr_oe <= 1'b0;
               end
               state <= MX_WAIT;
            end
            MX_WAIT: begin
               if (acked || timeout) begin
                  if (acked && bus.m_read) begin
                     rdata <= bus.dram_rdata;
                  end
                  bus.m_addr_oe <= 1'b0;
                  bus.m_data_oe <= 1'b0;
                  state <= MX_IDLE;
               end else begin
                  wait_cnt <= 16'(wait_cnt + 16'h0001);
               end
            end
            default: state <= MX_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// ### sim/dcxm_properties.sv
// link checker for the dram port: strobe, address and acknowledge order
// assumes zero extra row and column cycles in the timing register
`timescale 1ns/1ns
`default_nettype none
module dcxm_properties (
   input wire logic clk, // system clock
   input wire logic rst_n, // master reset
   input wire dcxm_pkg::dcxm_addr_type addr, // resolved address
   input wire dcxm_pkg::dcxm_addr_type d_addr, // device address
   input wire logic d_addr_oe, // device drives address
   input wire logic m_read, // direction
   input wire logic transfer_start_n, // start strobe
   input wire logic transfer_ack_n, // acknowledge
   input wire logic ack_oe, // acknowledge driven
   input wire logic [1:0] ras_n, // row strobes
   input wire logic [3:0] cas_n, // column strobes
   input wire logic dram_write_n // dram write line
);
   import dcxm_pkg::*;
   dcxm_addr_type cap;
   logic cap_rd;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // shadow of what the device should have captured
   always_ff @(posedge clk) begin
      if (!transfer_start_n) begin
         cap <= addr;
         cap_rd <= m_read;
      end
   end
   AST_ROW_ADDR: assert property ($rose(d_addr_oe) |-> d_addr == cap && dram_write_n == cap_rd)
      else $error("row address or write line wrong");
   AST_COL_ADDR: assert property ($rose(d_addr_oe) |=> d_addr_oe && d_addr[27:9] == cap[18:0])
      else $error("column address wrong");
   AST_RAS_AFTER_ROW: assert property ($rose(d_addr_oe) |-> $past(ras_n) == 2'h3 && ras_n != 2'h3)
      else $error("row strobe not after row address");
   AST_DRIVE_WITH_RAS: assert property (d_addr_oe && !$rose(d_addr_oe) |-> ras_n != 2'h3)
      else $error("address driven without row strobe");
   AST_ACK_NEG_FIRST: assert property ($rose(ack_oe) |-> transfer_ack_n && $past(cas_n) == 4'hf && cas_n != 4'hf
      ##1 !transfer_ack_n)
      else $error("acknowledge not driven negated first");
   AST_ACK_ONE: assert property (ack_oe && !transfer_ack_n |=> ack_oe && transfer_ack_n ##1 !ack_oe)
      else $error("acknowledge pulse or float wrong");
   AST_CAS_AT_ACK: assert property (ack_oe && !transfer_ack_n |-> cas_n != 4'hf && ras_n != 2'h3)
      else $error("strobes not low at acknowledge");
   AST_FLOAT: assert property (ack_oe && !transfer_ack_n |=> !d_addr_oe ##1 ras_n == 2'h3)
      else $error("address or row strobe not released");
endmodule
`default_nettype wire

// ### sim/dcxm_test.sv
// bench: master end and dram port joined by the link
// assumes 25 MHz clock; the bench plays the dram data pins
`timescale 1ns/1ns
`default_nettype none
module dcxm_test;
   import dcxm_pkg::*;
   localparam logic [31:0] RDV = 32'h3c5a96e1;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic norm_rst_n = 1'b0;
   logic rate_wr = 1'b0;
   logic timing_wr = 1'b0;
   logic [11:0] rate_wdata = 12'h000;
   logic [15:0] timing_wdata = 16'h0000;
   logic [1:0] bank_en = 2'h3;
   dcxm_addr_type [1:0] bank_base = {28'h0100000, 28'h0000000};
   dcxm_addr_type [1:0] bank_mask = {2{28'h00fffff}};
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout, hresp, busy, doe, we_ack, busy_ack;
   logic [31:0] hrdata, md_ack, rd;
   logic [11:0] rate_q;
   logic [15:0] timing_q;
   logic [1:0] ras_ack;
   logic [3:0] cas_ack;
   int miscompares = 0;
   int checks = 0;
   int cnt = 0;
   int lat = 0;
   int ncbr = 0;
   always #20 clk = ~clk;
   dcxm_if ifc (.clk(clk));
   // released data pins show the inverse of the read word
   assign ifc.dram_rdata = (ifc.cas_n != 4'hf) ? RDV : ~RDV;
   dcxm_device i_dcxm_device (.clk(clk), .rst_n(rst_n), .norm_rst_n(norm_rst_n), .bus(ifc.dev), .rate_wr(rate_wr),
      .rate_wdata(rate_wdata), .timing_wr(timing_wr), .timing_wdata(timing_wdata), .bank_en(bank_en),
      .bank_base(bank_base), .bank_mask(bank_mask), .refresh_rate_reg(rate_q), .dram_timing_reg(timing_q), .busy(busy));
   dcxm_master i_dcxm_master (.clk(clk), .rst_n(rst_n), .bus(ifc.mst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp));
   dcxm_properties chk_link (.clk(clk), .rst_n(rst_n), .addr(ifc.addr), .d_addr(ifc.d_addr), .d_addr_oe(ifc.d_addr_oe),
      .m_read(ifc.m_read), .transfer_start_n(ifc.transfer_start_n), .transfer_ack_n(ifc.transfer_ack_n),
      .ack_oe(ifc.ack_oe), .ras_n(ifc.ras_n), .cas_n(ifc.cas_n), .dram_write_n(ifc.dram_write_n));
   // link monitor: cycles from start to acknowledge, what stood at it
   always @(posedge clk) begin
      cnt = ifc.transfer_start_n ? cnt + 1 : 0;
      doe = ifc.transfer_start_n & (doe | ifc.d_addr_oe);
      if (ifc.ack_oe && !ifc.transfer_ack_n) begin
         lat = cnt;
         we_ack = ifc.dram_write_n;
         ras_ack = ifc.ras_n;
         cas_ack = ifc.cas_n;
         busy_ack = busy;
         md_ack = ifc.m_data & {32{ifc.m_data_oe}};
      end
      if (ifc.cas_n == 4'h0 && ifc.ras_n == 2'h3)
         ncbr = ncbr + 1;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks = checks + 1;
      if (got !== exp) begin
         miscompares = miscompares + 1;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic ahb(input logic wr, input logic [7:0] off, input logic [31:0] wd);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, off};
      hwrite <= wr;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic cfg(input logic is_rate, input logic [15:0] v);
      @(posedge clk);
      rate_wr <= is_rate;
      timing_wr <= !is_rate;
      rate_wdata <= v[11:0];
      timing_wdata <= v;
      @(posedge clk);
      rate_wr <= 1'b0;
      timing_wr <= 1'b0;
   endtask
   // ctrl: bit0 read, bits2:1 size, bit3 release; pre forces a refresh just before start
   task automatic xfer(input logic [27:0] a, input logic [3:0] ctrl, input logic pre);
      int n;
      ahb(1'b1, 8'h00, {4'h0, a});
      ahb(1'b1, 8'h04, {28'h0, ctrl});
      ahb(1'b1, 8'h0c, 32'h0000a55a);
      if (pre)
         cfg(1'b1, 16'h0000);
      ahb(1'b1, 8'h08, 32'h1);
      n = 0;
      do begin
         ahb(1'b0, 8'h14, 32'h0);
         n = n + 1;
      end while (rd[2:1] == 2'h0 && n < 60);
      ahb(1'b1, 8'h14, 32'h6);
   endtask
   task automatic t_reset;
      int n0;
      rst_n <= 1'b0;
      norm_rst_n <= 1'b0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      norm_rst_n <= 1'b1;
      n0 = ncbr;
      repeat (200) @(posedge clk);
      chk(rate_q, 32'h0);
      chk(timing_q, 32'h0);
      chk(ncbr - n0, 32'h0);
   endtask
   task automatic t_hits;
      logic [27:0] ta[3] = '{28'h0000100, 28'h0100002, 28'h00abcd4};
      logic [3:0] tc[3] = '{4'hb, 4'hc, 4'h9};
      logic [3:0] tcas[3] = '{4'he, 4'h3, 4'h0};
      logic [1:0] tras[3] = '{2'h2, 2'h1, 2'h2};
      cfg(1'b0, 16'h8000);
      for (int i = 0; i < 3; i++) begin
         xfer(ta[i], tc[i], 1'b0);
         chk(rd[2:1], 2'h1);
         chk(lat, 4);
         chk(busy_ack, 1'b1);
         chk(hresp, 1'b0);
         chk(ras_ack, tras[i]);
         chk(cas_ack, tcas[i]);
         chk(we_ack, tc[i][0]);
         chk(doe, 1'b1);
         if (tc[i][0]) begin
            chk(md_ack, 32'h0);
            ahb(1'b0, 8'h10, 32'h0);
            chk(rd, RDV);
         end else
            chk(md_ack, 32'h0000a55a);
      end
   endtask
   task automatic t_miss;
      bank_en <= 2'h1;
      xfer(28'h0100000, 4'hb, 1'b0);
      chk(rd[2:1], 2'h2);
      chk(doe, 1'b0);
      bank_en <= 2'h3;
      xfer(28'h8000000, 4'hb, 1'b0);
      chk(rd[2:1], 2'h2);
      chk(busy, 1'b0);
      chk(doe, 1'b0);
   endtask
   task automatic t_nodrive;
      cfg(1'b0, 16'h0000);
      // address drive off, so the master may keep the address on the bus
      xfer(28'h0000040, 4'h3, 1'b0);
      chk(rd[2:1], 2'h1);
      chk(doe, 1'b0);
      chk(lat, 4);
      chk(ras_ack, 2'h2);
   endtask
   task automatic t_refresh;
      int n0;
      cfg(1'b0, 16'h8000);
      n0 = ncbr;
      xfer(28'h0000080, 4'hb, 1'b1);
      chk(rd[2:1], 2'h1);
      chk(lat > 4, 1'b1);
      chk(ncbr - n0, 32'h1);
      cfg(1'b1, 16'h0001);
      n0 = ncbr;
      norm_rst_n <= 1'b0;
      repeat (100) @(posedge clk);
      chk(ncbr - n0 > 4, 1'b1);
      norm_rst_n <= 1'b1;
      @(posedge clk);
      chk(rate_q, 32'h1);
      chk(timing_q, 32'h8000);
   endtask
   initial begin
      #(40 * 20000);
      miscompares = miscompares + 1;
      tally_and_finish;
   end
   initial begin
      t_reset;
      t_hits;
      t_miss;
      t_nodrive;
      t_refresh;
      t_reset;
      tally_and_finish;
   end
endmodule
`default_nettype wire
